// ===== logic/gpp_pkg.sv
// Package for the general-purpose port block: register map, field
// positions and reset values.
// Assumes a 32-bit AHB-Lite register bus, one word per register.
package gpp_pkg;

  // ----------------------------------------------------------------------
  // Register indices (printed offsets)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_P0_VALUES = 8'h00;
  localparam logic [7:0] IDX_P1_VALUES = 8'h01;
  localparam logic [7:0] IDX_P2_VALUES = 8'h02;
  localparam logic [7:0] IDX_P01_SETUP = 8'h06;
  localparam logic [7:0] IDX_IRQA_SETUP = 8'h08;
  localparam logic [7:0] IDX_IRQB_SETUP = 8'h09;
  localparam logic [7:0] IDX_P1_SETUP_BASE = 8'h10;
  localparam logic [7:0] IDX_MISC_CTRL = 8'h20;

  // ----------------------------------------------------------------------
  // Field positions in a pin setup register
  // ----------------------------------------------------------------------
  localparam int BIT_ALT_USE = 7;
  localparam int BIT_INT_EN = 6;
  localparam int BIT_ACT_LOW = 5;
  localparam int BIT_TTL = 4;
  localparam int BIT_SINK = 3;
  localparam int BIT_OPEN_DRAIN = 2;
  localparam int BIT_PULL_UP = 1;
  localparam int BIT_OUT_EN = 0;

  // Writable bits of the setup and data registers; the rest read as zero.
  localparam logic [7:0] MASK_P01_SETUP = 8'h7F;
  localparam logic [7:0] MASK_IRQ_SETUP = 8'h77;
  localparam logic [7:0] MASK_P1_SETUP = 8'hFF;
  localparam logic [7:0] MASK_P0_DATA = 8'h9A;
  localparam logic [7:0] MASK_P2_DATA = 8'h03;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Misc control bits.
  localparam int BIT_XOSC_ON = 0;
  localparam int BIT_SPI_ON = 1;

endpackage

// ===== logic/gpp_port.sv
// General-purpose port logic: data registers, per-pin setup, pin drive,
// pin interrupts and the two external interrupt lines.
// Assumes an AHB-Lite master on hclk and asynchronous pins at the edge.
`timescale 1ns/1ps

// Function
// - Data reads return sampled pin levels.
// - Data writes set values on enabled outputs.
// - Port 0 pins at bits 7,4,3,1.
// - Port 1 full; bits 3-6 serial pins.
// - Port 2 only bits 1:0, reset zero.
// - All setup bits reset to zero.
// - Interrupt enable works for inputs and outputs.
// - Edge triggered; shared needs all inactive.
// - Active-low bit selects interrupt polarity.
// - Threshold bit picks TTL or CMOS.
// - Strong sink bit; port0 pin1 normal only. The code also masks the sink bit on port 0 pins 3 and 4.
// - Open drain: one floats, zero drives low.
// - Pull-up bit connects pull-up resistor.
// - Output enable turns driver on.
// - Crystal on forces crystal pins undriven.
// - Serial alternate function takes pin drive.
// - External interrupt pins, separate edge pulses.
// - Output write to active level raises interrupt.
// - Polarity toggle may raise an interrupt.
module gpp_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] p0_pin_in,
  input wire logic [7:0] p1_pin_in,
  input wire logic [1:0] p2_pin_in,
  output logic [7:0] p0_pin_out,
  output logic [7:0] p0_pin_oe_n,
  output logic [7:0] p0_pull_up,
  output logic [7:0] p0_ttl_sel,
  output logic [7:0] p0_strong_sink,
  output logic [7:0] p1_pin_out,
  output logic [7:0] p1_pin_oe_n,
  output logic [7:0] p1_pull_up,
  output logic [7:0] p1_ttl_sel,
  output logic [7:0] p1_strong_sink,
  output logic [1:0] p2_pin_out,
  output logic [1:0] p2_pin_oe_n,
  input wire logic [3:0] serial_out_val,
  input wire logic [3:0] serial_out_en,
  output logic pin_irq,
  output logic external_irq_a,
  output logic external_irq_b
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [31:0] rdata_q;
  wire access_ok = hsel & hready & htrans[1];
  wire [7:0] a_idx = haddr[9:2];
  wire wr_now = wr_pend_q;
  wire [7:0] wd = hwdata[7:0];

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [17:0] pin_s1_q;
  logic [17:0] pin_s2_q;
  wire [7:0] p0_now = pin_s2_q[7:0];
  wire [7:0] p1_now = pin_s2_q[15:8];
  wire [1:0] p2_now = pin_s2_q[17:16];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= 18'h00000;
      pin_s2_q <= 18'h00000;
    end else begin
      pin_s1_q <= {p2_pin_in, p1_pin_in, p0_pin_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] p0_data_q;
  logic [7:0] p1_data_q;
  logic [1:0] p2_data_q;
  logic [7:0] p01_setup_q;
  logic [7:0] irqa_setup_q;
  logic [7:0] irqb_setup_q;
  logic [7:0] p1_setup_q [0:7];
  logic [1:0] misc_q;

  wire wr_p0 = wr_now && wr_idx_q == gpp_pkg::IDX_P0_VALUES;
  wire wr_p1 = wr_now && wr_idx_q == gpp_pkg::IDX_P1_VALUES;
  wire wr_p2 = wr_now && wr_idx_q == gpp_pkg::IDX_P2_VALUES;
  wire wr_p01 = wr_now && wr_idx_q == gpp_pkg::IDX_P01_SETUP;
  wire wr_ia = wr_now && wr_idx_q == gpp_pkg::IDX_IRQA_SETUP;
  wire wr_ib = wr_now && wr_idx_q == gpp_pkg::IDX_IRQB_SETUP;
  wire wr_misc = wr_now && wr_idx_q == gpp_pkg::IDX_MISC_CTRL;
  wire wr_p1s = wr_now && wr_idx_q[7:3] == gpp_pkg::IDX_P1_SETUP_BASE[7:3];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end else begin
      wr_pend_q <= access_ok & hwrite;
      wr_idx_q <= a_idx;
    end
  end

  // Data registers; reserved positions never store a written one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p0_data_q <= gpp_pkg::DATA_RESET;
      p1_data_q <= gpp_pkg::DATA_RESET;
      p2_data_q <= gpp_pkg::DATA_RESET[1:0];
    end else begin
      if (wr_p0) p0_data_q <= wd & gpp_pkg::MASK_P0_DATA;
      if (wr_p1) p1_data_q <= wd;
      if (wr_p2) p2_data_q <= wd[1:0];
    end
  end

  // Setup registers of port 0; the masks keep reserved bits at zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p01_setup_q <= gpp_pkg::SETUP_RESET;
      irqa_setup_q <= gpp_pkg::SETUP_RESET;
      irqb_setup_q <= gpp_pkg::SETUP_RESET;
    end else begin
      if (wr_p01) p01_setup_q <= wd & gpp_pkg::MASK_P01_SETUP;
      if (wr_ia) irqa_setup_q <= wd & gpp_pkg::MASK_IRQ_SETUP;
      if (wr_ib) irqb_setup_q <= wd & gpp_pkg::MASK_IRQ_SETUP;
    end
  end

  // Misc control holds the crystal and serial engine switches.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      misc_q <= 2'h0;
    end else if (wr_misc) begin
      misc_q <= wd[1:0];
    end
  end

  // Port 1 setup registers, one per pin; only pins 3..6 keep the
  // alternate-use bit since only they have a serial function.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_p1s
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          p1_setup_q[gi] <= gpp_pkg::SETUP_RESET;
        end else if (wr_p1s && wr_idx_q[2:0] == gi) begin
          p1_setup_q[gi] <= (gi >= 3 && gi <= 6) ? wd : {1'b0, wd[6:0]};
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Per-pin setup view (index 0..7 port 0, 8..15 port 1)
  // ----------------------------------------------------------------------
  logic [7:0] cfg [0:15];
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      cfg[i] = 8'h00;
    end
    cfg[1] = p01_setup_q;
    cfg[3] = irqa_setup_q;
    cfg[4] = irqb_setup_q;
    for (int i = 0; i < 8; i++) begin
      cfg[8 + i] = p1_setup_q[i];
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  wire xosc_on = misc_q[gpp_pkg::BIT_XOSC_ON];
  wire spi_on = misc_q[gpp_pkg::BIT_SPI_ON];
  wire [15:0] data_all = {p1_data_q, p0_data_q};
  logic [15:0] drv_en;
  logic [15:0] drv_val;
  logic [15:0] oe_n_d;
  logic [15:0] out_d;
  logic [15:0] pull_d;
  logic [15:0] ttl_d;
  logic [15:0] sink_d;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      drv_en[i] = cfg[i][gpp_pkg::BIT_OUT_EN];
      drv_val[i] = data_all[i];
      if (i >= 11 && i <= 14 && spi_on && cfg[i][gpp_pkg::BIT_ALT_USE]) begin
        drv_en[i] = serial_out_en[i - 11];
        drv_val[i] = serial_out_val[i - 11];
      end
      if (i <= 1 && xosc_on) begin
        drv_en[i] = 1'b0;
      end
      if (cfg[i][gpp_pkg::BIT_OPEN_DRAIN]) begin
        oe_n_d[i] = !(drv_en[i] && !drv_val[i]);
        out_d[i] = 1'b0;
      end else begin
        oe_n_d[i] = !drv_en[i];
        out_d[i] = drv_val[i];
      end
      pull_d[i] = cfg[i][gpp_pkg::BIT_PULL_UP];
      ttl_d[i] = cfg[i][gpp_pkg::BIT_TTL];
      sink_d[i] = cfg[i][gpp_pkg::BIT_SINK];
    end
    sink_d[1] = 1'b0;
  end

  wire [1:0] p2_oe_n_d = 2'h3;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p0_pin_out <= 8'h00;
      p1_pin_out <= 8'h00;
      p2_pin_out <= 2'h0;
      p0_pin_oe_n <= 8'hFF;
      p1_pin_oe_n <= 8'hFF;
      p2_pin_oe_n <= 2'h3;
    end else begin
      p0_pin_out <= out_d[7:0];
      p1_pin_out <= out_d[15:8];
      p2_pin_out <= p2_data_q;
      p0_pin_oe_n <= oe_n_d[7:0];
      p1_pin_oe_n <= oe_n_d[15:8];
      p2_pin_oe_n <= p2_oe_n_d;
    end
  end

  // Pad levels follow the setup bits one cycle after a write lands.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p0_pull_up <= 8'h00;
      p1_pull_up <= 8'h00;
      p0_ttl_sel <= 8'h00;
      p1_ttl_sel <= 8'h00;
      p0_strong_sink <= 8'h00;
      p1_strong_sink <= 8'h00;
    end else begin
      p0_pull_up <= pull_d[7:0];
      p1_pull_up <= pull_d[15:8];
      p0_ttl_sel <= ttl_d[7:0];
      p1_ttl_sel <= ttl_d[15:8];
      p0_strong_sink <= sink_d[7:0];
      p1_strong_sink <= sink_d[15:8];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  // The level is taken after polarity, so flipping the polarity bit can
  // itself make an edge; that is kept on purpose.
  wire [15:0] pins_now = {p1_now, p0_now};
  logic [15:0] act_lvl;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      act_lvl[i] = pins_now[i] ^ cfg[i][gpp_pkg::BIT_ACT_LOW];
    end
  end
  wire [15:0] int_en_v = {cfg[15][6], cfg[14][6], cfg[13][6], cfg[12][6],
                          cfg[11][6], cfg[10][6], cfg[9][6], cfg[8][6],
                          cfg[7][6], cfg[6][6], cfg[5][6], cfg[4][6],
                          cfg[3][6], cfg[2][6], cfg[1][6], cfg[0][6]};
  // Shared line: any enabled pin active; a new pulse needs all inactive.
  wire shared_any = |(act_lvl & int_en_v);
  logic shared_q;
  logic irq_a_lvl_q;
  logic irq_b_lvl_q;
  // The external lines are always armed here; their enables live in the
  // interrupt controller, outside this block.
  wire irq_a_lvl = act_lvl[3];
  wire irq_b_lvl = act_lvl[4];

  // ----------------------------------------------------------------------
  // Warm-up after reset
  // ----------------------------------------------------------------------
  // The synchronisers and the history flops reset low while an idle pin
  // may sit high; without this gate reset release would look like an edge.
  logic [1:0] warm_q;
  wire warm = warm_q == 2'h3;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warm_q <= 2'h0;
    end else if (!warm) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_q <= 1'b0;
      irq_a_lvl_q <= 1'b0;
      irq_b_lvl_q <= 1'b0;
      pin_irq <= 1'b0;
      external_irq_a <= 1'b0;
      external_irq_b <= 1'b0;
    end else begin
      shared_q <= shared_any;
      irq_a_lvl_q <= irq_a_lvl;
      irq_b_lvl_q <= irq_b_lvl;
      pin_irq <= warm & shared_any & ~shared_q;
      external_irq_a <= warm & irq_a_lvl & ~irq_a_lvl_q;
      external_irq_b <= warm & irq_b_lvl & ~irq_b_lvl_q;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  wire rd_p0 = a_idx == gpp_pkg::IDX_P0_VALUES;
  wire rd_p1 = a_idx == gpp_pkg::IDX_P1_VALUES;
  wire rd_p2 = a_idx == gpp_pkg::IDX_P2_VALUES;
  wire rd_p01 = a_idx == gpp_pkg::IDX_P01_SETUP;
  wire rd_ia = a_idx == gpp_pkg::IDX_IRQA_SETUP;
  wire rd_ib = a_idx == gpp_pkg::IDX_IRQB_SETUP;
  wire rd_misc = a_idx == gpp_pkg::IDX_MISC_CTRL;
  wire rd_p1s = a_idx[7:3] == gpp_pkg::IDX_P1_SETUP_BASE[7:3];
  // Data reads show the synchronised pins, so a value written to an
  // undriven pin does not read back; that is the intended behaviour.
  wire [7:0] rd_byte =
    rd_p0 ? (p0_now & gpp_pkg::MASK_P0_DATA) :
    rd_p1 ? p1_now :
    rd_p2 ? {6'h00, p2_now} :
    rd_p01 ? p01_setup_q :
    rd_ia ? irqa_setup_q :
    rd_ib ? irqb_setup_q :
    rd_misc ? {6'h00, misc_q} :
    rd_p1s ? p1_setup_q[a_idx[2:0]] : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (access_ok && !hwrite) begin
      rdata_q <= {24'h000000, rd_byte};
    end
  end

  assign hrdata = rdata_q;

  // ----------------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------------
  // Every access completes with no wait state and an OKAY response; the
  // outputs are still flops so that the top keeps registered outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule

// ===== bench/gpp_port_assertions.sv
// Checker for the port block, bound to its top module.
// Assumes the single hclk domain and the active-low hresetn.
`timescale 1ns/1ps
module gpp_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] p0_pin_oe_n,
  input wire logic [7:0] p0_strong_sink,
  input wire logic [1:0] p2_pin_oe_n,
  input wire logic pin_irq,
  input wire logic external_irq_a,
  input wire logic external_irq_b
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic wr = hsel & hready & htrans[1] & hwrite;
  property p_rst;
    $rose(hresetn) |-> p0_pin_oe_n == 8'hFF && p0_strong_sink == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad value after reset");
  property p_sink; p0_strong_sink[1] == 1'b0; endproperty
  a_sink: assert property (p_sink) else $error("strong sink on pin 1");
  property p_p2; p2_pin_oe_n == 2'h3; endproperty
  a_p2: assert property (p_p2) else $error("port 2 driven");
  property p_rd; hrdata[31:8] == 24'h0; endproperty
  a_rd: assert property (p_rd) else $error("upper read bits set");
  property p_irqa; external_irq_a |=> !external_irq_a; endproperty
  a_irqa: assert property (p_irqa) else $error("irq a not a pulse");
  property p_irqb; $rose(external_irq_b) |=> $fell(external_irq_b); endproperty
  a_irqb: assert property (p_irqb) else $error("irq b not a pulse");
  property p_pirq; pin_irq |=> !pin_irq; endproperty
  a_pirq: assert property (p_pirq) else $error("pin irq repeats");
  // Port 0 drive changes come only from register writes, a few cycles later.
  property p_oe;
    $changed(p0_pin_oe_n) |-> $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
  endproperty
  a_oe: assert property (p_oe) else $error("enable moved unasked");
  c_irqa: cover property (external_irq_a);
  c_irqb: cover property (external_irq_b);
  c_pirq: cover property (pin_irq);
endmodule

bind gpp_port gpp_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .p0_pin_oe_n(p0_pin_oe_n), .p0_strong_sink(p0_strong_sink),
  .p2_pin_oe_n(p2_pin_oe_n), .pin_irq(pin_irq),
  .external_irq_a(external_irq_a), .external_irq_b(external_irq_b));

// ===== bench/gpp_pins.sv
// Model of the circuitry on one port's pins.
// Assumes the bench says which pins outside parts drive.
`timescale 1ns/1ps
module gpp_pins #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] pull_up,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin_in
);
  // ----------------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------------
  // A floating pin wanders, so no check may lean on it.
  logic [W-1:0] noise_q = '0;
  always @(posedge hclk) noise_q <= ~noise_q;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_up[i]) pin_in[i] = 1'b1;
      else pin_in[i] = noise_q[i];
    end
  end
endmodule

// ===== bench/test_gpio_port_data_and_pin_config.sv
// Self-checking bench: bus master, pin models and checks.
// Assumes the port block, its checker and the pin model.
`timescale 1ns/1ps
module test_gpio_port_data_and_pin_config;
  // ----------------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pin_irq, irq_a, irq_b;
  logic [7:0] p0_in, p0_out, p0_oe, p0_pu, p0_ttl, p0_sk;
  logic [7:0] p1_in, p1_out, p1_oe, p1_pu, p1_ttl, p1_sk;
  logic [1:0] p2_in, p2_out, p2_oe;
  logic [7:0] e0v = 8'hFF, e1v = 8'h00, e0e = 8'h9A, e1e = 8'hFF, rd, v;
  logic [3:0] sv = 4'h0, se = 4'h0;
  logic [7:0] ix [5] = '{8'h06, 8'h08, 8'h09, 8'h13, 8'h30};
  logic [7:0] pv [8] = '{0, 2, 6, 4, 6, 0, 4, 2};
  logic [7:0] pe [8] = '{0, 1, 0, 0, 0, 0, 0, 1};
  int errors = 0;
  int check_count = 0;
  int pulses, i, j, k, s;
  always #10 hclk = ~hclk;
  gpp_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .p0_pin_in(p0_in),
    .p1_pin_in(p1_in), .p2_pin_in(p2_in), .p0_pin_out(p0_out),
    .p0_pin_oe_n(p0_oe), .p0_pull_up(p0_pu), .p0_ttl_sel(p0_ttl),
    .p0_strong_sink(p0_sk), .p1_pin_out(p1_out), .p1_pin_oe_n(p1_oe),
    .p1_pull_up(p1_pu), .p1_ttl_sel(p1_ttl), .p1_strong_sink(p1_sk),
    .p2_pin_out(p2_out), .p2_pin_oe_n(p2_oe), .serial_out_val(sv),
    .serial_out_en(se), .pin_irq(pin_irq), .external_irq_a(irq_a),
    .external_irq_b(irq_b));
  gpp_pins pm0 (.hclk(hclk), .pin_out(p0_out), .oe_n(p0_oe),
    .pull_up(p0_pu), .ext_val(e0v), .ext_en(e0e), .pin_in(p0_in));
  gpp_pins pm1 (.hclk(hclk), .pin_out(p1_out), .oe_n(p1_oe),
    .pull_up(p1_pu), .ext_val(e1v), .ext_en(e1e), .pin_in(p1_in));
  gpp_pins #(.W(2)) pm2 (.hclk(hclk), .pin_out(p2_out), .oe_n(p2_oe),
    .pull_up(2'h0), .ext_val(2'h3), .ext_en(2'h3), .pin_in(p2_in));
  task automatic close_out;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic edge_rdy;
    int n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        close_out();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(logic [7:0] a, logic w, logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, a, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    edge_rdy();
    rd = hrdata[7:0];
  endtask
  task automatic rc(string n, logic [7:0] a, logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(n, rd, e);
  endtask
  task automatic count(int w);
    pulses = 0;
    repeat (10) begin
      @(posedge hclk);
      if ((w == 0 ? irq_a : w == 1 ? irq_b : pin_irq) === 1'b1) pulses++;
    end
  endtask
  function automatic logic [7:0] msk(logic [7:0] a);
    if (a == gpp_pkg::IDX_P01_SETUP) return gpp_pkg::MASK_P01_SETUP;
    if (a == 8'h08 || a == 8'h09) return gpp_pkg::MASK_IRQ_SETUP;
    if (a[7:4] == 4'h1) return gpp_pkg::MASK_P1_SETUP;
    return 8'h00;
  endfunction
  initial begin
    void'($urandom(32'h6bbe));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("oe_rst", p0_oe & p1_oe, 8'hFF);
    for (k = 0; k < 5; k++) begin
      rc("rst", ix[k], 8'h00);
      v = 8'($urandom);
      bus(ix[k], 1'b1, v);
      rc("mask", ix[k], v & msk(ix[k]));
      bus(ix[k], 1'b1, 8'h00);
    end
    for (i = 0; i < 8; i++) bus(8'h10 + 8'(i), 1'b1, 8'h01);
    repeat (6) begin
      v = 8'($urandom);
      e1v <= ~v;
      bus(gpp_pkg::IDX_P1_VALUES, 1'b1, v);
      repeat (4) @(posedge hclk);
      chk("p1out", p1_out, v);
      chk("p1oe", p1_oe, 8'h00);
      rc("p1rd", gpp_pkg::IDX_P1_VALUES, v);
    end
    for (i = 0; i < 8; i++) bus(8'h10 + 8'(i), 1'b1, 8'h00);
    repeat (4) @(posedge hclk);
    rc("p1in", gpp_pkg::IDX_P1_VALUES, e1v);
    e1v <= 8'hFF;
    bus(8'h10, 1'b1, 8'h05);
    for (i = 0; i < 2; i++) begin
      bus(gpp_pkg::IDX_P1_VALUES, 1'b1, 8'(i));
      repeat (4) @(posedge hclk);
      chk("od", {7'h0, p1_oe[0]}, 8'(i));
      rc("odrd", gpp_pkg::IDX_P1_VALUES, {7'h7F, i[0]});
    end
    bus(8'h10, 1'b1, 8'h00);
    for (k = 0; k < 2; k++) begin
      v = k ? 8'h00 : 8'h1A;
      bus(8'h17, 1'b1, v);
      bus(gpp_pkg::IDX_P01_SETUP, 1'b1, v);
      repeat (3) @(posedge hclk);
      chk("cfg1", {5'h0, p1_pu[7], p1_ttl[7], p1_sk[7]},
        {5'h0, {3{v[3]}}});
      chk("cfg0", {5'h0, p0_pu[1], p0_ttl[1], p0_sk[1]},
        {5'h0, {2{v[3]}}, 1'b0});
    end
    rc("p0rd", gpp_pkg::IDX_P0_VALUES, 8'h9A);
    rc("p2rd", gpp_pkg::IDX_P2_VALUES, 8'h03);
    bus(gpp_pkg::IDX_P2_VALUES, 1'b1, 8'hFE);
    repeat (2) @(posedge hclk);
    chk("p2out", {6'h0, p2_out}, 8'h02);
    bus(gpp_pkg::IDX_P01_SETUP, 1'b1, 8'h01);
    for (k = 1; k >= 0; k--) begin
      bus(gpp_pkg::IDX_MISC_CTRL, 1'b1, 8'(k));
      repeat (3) @(posedge hclk);
      chk("xosc", {7'h0, p0_oe[1]}, 8'(k));
    end
    bus(gpp_pkg::IDX_P01_SETUP, 1'b1, 8'h00);
    bus(8'h13, 1'b1, 8'h81);
    bus(gpp_pkg::IDX_MISC_CTRL, 1'b1, 8'h02);
    sv <= 4'hF;
    for (k = 0; k < 2; k++) begin
      se <= 4'(k);
      repeat (3) @(posedge hclk);
      chk("spi", {6'h0, p1_oe[3], p1_out[3] & ~p1_oe[3]},
        k ? 8'h01 : 8'h02);
    end
    bus(8'h13, 1'b1, 8'h00);
    for (s = 0; s < 2; s++) begin
      for (j = 0; j < 4; j++) begin
        if (j == 2) begin
          bus(gpp_pkg::IDX_IRQA_SETUP + 8'(s), 1'b1, 8'h20);
          count(s);
        end
        e0v[3 + s] <= j[0];
        count(s);
        chk("xirq", 8'(pulses), 8'(j == 1 || j == 2));
      end
      bus(gpp_pkg::IDX_IRQA_SETUP + 8'(s), 1'b1, 8'h01);
      e0e[3 + s] <= 1'b0;
      bus(gpp_pkg::IDX_P0_VALUES, 1'b1, 8'h00);
      count(s);
      bus(gpp_pkg::IDX_P0_VALUES, 1'b1, 8'(8'h08 << s));
      count(s);
      chk("outirq", 8'(pulses), 8'h01);
      bus(gpp_pkg::IDX_IRQA_SETUP + 8'(s), 1'b1, 8'h00);
      e0e[3 + s] <= 1'b1;
    end
    bus(8'h11, 1'b1, 8'h40);
    bus(8'h12, 1'b1, 8'h40);
    for (j = 0; j < 8; j++) begin
      if (j == 6) bus(8'h12, 1'b1, 8'h00);
      e1v <= pv[j];
      count(2);
      chk("pirq", 8'(pulses), pe[j]);
    end
    close_out();
  end
endmodule
